//--- gpio_port_consts.vh
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// ----------------------------------------
// register byte offsets on the AHB-Lite bus
// ----------------------------------------
`define OFS_SELECT      8'h00
`define OFS_DIR_LOW     8'h04
`define OFS_DIR_HIGH    8'h08
`define OFS_DATA_LOW    8'h0C
`define OFS_DATA_HIGH   8'h10
`define OFS_EN_LOW      8'h14
`define OFS_EN_HIGH     8'h18
`define OFS_FLAG_LOW    8'h1C
`define OFS_FLAG_HIGH   8'h20
`define OFS_IRQ_STATUS  8'h24
`define OFS_IRQ_MASK    8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define HI_DATA_BIT     0
`define HI_SELECT_BIT   1
`define STAT_CHANGE_BIT 0
`define LINE_HIGH       8
`define LONE_BIT        0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SELECT      8'hFF
`define RST_DIR_LOW     8'h00
`define RST_DIR_HIGH    1'h0
`define RST_DATA_LOW    8'h00
`define RST_DATA_HIGH   2'h2
`define RST_EN_LOW      8'h00
`define RST_EN_HIGH     1'h0
`define RST_FLAGS       9'h000
`define RST_STAT        1'h0
`define RST_MASK        1'h0

// ----------------------------------------
// bus constants
// ----------------------------------------
`define HRESP_OKAY      1'h0
`define ADDR_DECODE_W   8

`endif

//--- line_sync_edge.v
`timescale 1ns/1ps

// ----------------------------------------
// two-stage synchroniser with change detect
// ----------------------------------------
module line_sync_edge #(
  parameter WIDTH = 9
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             srst_in,
  // raw pad levels
  input  wire [WIDTH-1:0] raw_in,
  // synchronised level and change strobe
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] change_out
);

  reg [WIDTH-1:0] meta_ff;   // first stage, read only by stage two
  reg [WIDTH-1:0] sync_ff;   // second stage, safe to use
  reg [WIDTH-1:0] prev_ff;   // previous synchronised sample

  // pads reset low, matching the pull-downs, so no spurious change
  always @(posedge clk_in) begin
    if (srst_in) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
      prev_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out  = sync_ff;
  assign change_out = sync_ff ^ prev_ff;

endmodule

//--- gpio_port.v
// Contract
// - nine lines shared with serial, clock, pwm
// - select bit set means general-purpose line
// - select register resets to all ones
// - line 8 select is high data bit 1
// - direction bit set means output
// - direction bits reset to input
// - data reads inputs, writes drive outputs
// - source needs enable, gp mode, input
// - any edge on source sets change flag
// - any flag raises one shared interrupt
// - reading a flag register clears both
// - interrupt enables reset to cleared
// - pull-down makes open lines read low
// - active-low irq held until flags read
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gpio_port_consts.vh"

module gpio_port #(
  parameter LOW_LINES = 8
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        srst_in,
  // ahb-lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output wire [31:0] hrdata_out,
  // pads of the nine lines
  input  wire [LOW_LINES:0] pad_in,
  output wire [LOW_LINES:0] pad_out,
  output wire [LOW_LINES:0] pad_oe_out,
  output wire [LOW_LINES:0] pull_down_en_out,
  // alternate functions sharing the pads
  input  wire [LOW_LINES:0] alt_drive_in,
  input  wire [LOW_LINES:0] alt_oe_in,
  output wire [LOW_LINES:0] alt_level_out,
  // interrupts
  output wire        peripheral_irq_line_n_out,
  output wire        irq_out
);

  // ----------------------------------------
  // local widths and states
  // ----------------------------------------
  localparam LINES = LOW_LINES + 1;

  localparam [1:0] BUS_IDLE  = 2'h0;  // no data phase pending
  localparam [1:0] BUS_WRITE = 2'h1;  // write data phase
  localparam [1:0] BUS_READ  = 2'h2;  // read data phase, one wait

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [LOW_LINES-1:0] select_ff;      // line_function_select
  reg [LOW_LINES-1:0] dir_low_ff;     // line_direction_low
  reg                 dir_high_ff;    // line_direction_high
  reg [LOW_LINES-1:0] data_low_ff;    // line_data_low, output latch
  reg [1:0]           data_high_ff;   // line_data_high_and_select
  reg [LOW_LINES-1:0] en_low_ff;      // change_irq_enable_low
  reg                 en_high_ff;     // change_irq_enable_high
  reg [LINES-1:0]     flag_ff;        // both change flag registers
  reg                 stat_ff;        // sticky change event
  reg                 mask_ff;        // interrupt mask
  reg [LINES-1:0]     pad_out_ff;     // registered pad drive
  reg [LINES-1:0]     pad_oe_ff;      // registered pad enable
  reg [LINES-1:0]     pull_ff;        // pull-down enables

  // bus state
  reg [1:0]  bus_state_ff;            // data phase kind
  reg [1:0]  nxt_bus_state;
  reg [`ADDR_DECODE_W-1:0] addr_ff;   // captured address
  reg [31:0] hrdata_ff;               // read data, from a flop
  reg [31:0] nxt_rdata;               // read mux result

  // ----------------------------------------
  // nine-line views of the split registers
  // ----------------------------------------
  wire [LINES-1:0] gp_mode;           // set: general-purpose line
  wire [LINES-1:0] dir_all;           // set: output
  wire [LINES-1:0] dout_all;          // output latch
  wire [LINES-1:0] en_all;            // change interrupt enable
  wire [LINES-1:0] level;             // synchronised pad level
  wire [LINES-1:0] change;            // level differs from last
  wire [LINES-1:0] source;            // valid interrupt source
  wire [LINES-1:0] hit;               // edge on a valid source
  wire [LINES-1:0] rd_view;           // data as read by software

  assign gp_mode  = {data_high_ff[`HI_SELECT_BIT], select_ff};
  assign dir_all  = {dir_high_ff, dir_low_ff};
  assign dout_all = {data_high_ff[`HI_DATA_BIT], data_low_ff};
  assign en_all   = {en_high_ff, en_low_ff};

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  // pads come from the board, so both stages sit before any use
  line_sync_edge #(
    .WIDTH (LINES)
  ) u_sync (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .raw_in     (pad_in),
    .level_out  (level),
    .change_out (change)
  );

  // alternate functions see the same clean level
  assign alt_level_out = level;

  // ----------------------------------------
  // per-line source qualification
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_line
      // only an enabled general-purpose input may interrupt
      assign source[g]  = en_all[g] & gp_mode[g] & ~dir_all[g];
      // either edge counts
      assign hit[g]     = source[g] & change[g];
      // inputs read the pad, outputs read back the latch
      assign rd_view[g] = dir_all[g] ? dout_all[g] : level[g];
    end
  endgenerate

  // ----------------------------------------
  // ahb-lite address phase decode
  // ----------------------------------------
  wire accept;      // address phase taken this edge
  wire wr_commit;   // write data phase ends this edge
  wire rd_commit;   // read data sampled into hrdata_ff this edge
  wire flag_read;   // a flag register is being read

  assign accept    = hsel_in & htrans_in[1] & hready_in;
  assign wr_commit = (bus_state_ff == BUS_WRITE);
  assign rd_commit = (bus_state_ff == BUS_READ);
  assign flag_read = rd_commit &
                     ((addr_ff == `OFS_FLAG_LOW) | (addr_ff == `OFS_FLAG_HIGH));

  // read answers after one wait cycle so a write just before is seen
  assign hreadyout_out = ~rd_commit;
  assign hresp_out     = `HRESP_OKAY;
  assign hrdata_out    = hrdata_ff;

  // next bus state
  always @* begin
    nxt_bus_state = BUS_IDLE;
    case (bus_state_ff)
      BUS_IDLE,
      BUS_WRITE: begin
        // a new address phase may overlap the write data phase
        if (accept) begin
          nxt_bus_state = hwrite_in ? BUS_WRITE : BUS_READ;
        end
      end
      BUS_READ: begin
        // hready is low here, so no address phase is taken
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  // bus state and captured address
  always @(posedge clk_in) begin
    if (srst_in) begin
      bus_state_ff <= BUS_IDLE;
      addr_ff      <= {`ADDR_DECODE_W{1'b0}};
    end else begin
      bus_state_ff <= nxt_bus_state;
      if (accept) begin
        addr_ff <= haddr_in[`ADDR_DECODE_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped offsets read as zero, reserved bits as zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (addr_ff)
      `OFS_SELECT: begin
        nxt_rdata[LOW_LINES-1:0] = select_ff;
      end
      `OFS_DIR_LOW: begin
        nxt_rdata[LOW_LINES-1:0] = dir_low_ff;
      end
      `OFS_DIR_HIGH: begin
        nxt_rdata[`LONE_BIT] = dir_high_ff;
      end
      `OFS_DATA_LOW: begin
        nxt_rdata[LOW_LINES-1:0] = rd_view[LOW_LINES-1:0];
      end
      `OFS_DATA_HIGH: begin
        nxt_rdata[`HI_DATA_BIT]   = rd_view[`LINE_HIGH];
        nxt_rdata[`HI_SELECT_BIT] = data_high_ff[`HI_SELECT_BIT];
      end
      `OFS_EN_LOW: begin
        nxt_rdata[LOW_LINES-1:0] = en_low_ff;
      end
      `OFS_EN_HIGH: begin
        nxt_rdata[`LONE_BIT] = en_high_ff;
      end
      `OFS_FLAG_LOW: begin
        nxt_rdata[LOW_LINES-1:0] = flag_ff[LOW_LINES-1:0];
      end
      `OFS_FLAG_HIGH: begin
        nxt_rdata[`LONE_BIT] = flag_ff[`LINE_HIGH];
      end
      `OFS_IRQ_STATUS: begin
        nxt_rdata[`STAT_CHANGE_BIT] = stat_ff;
      end
      `OFS_IRQ_MASK: begin
        nxt_rdata[`STAT_CHANGE_BIT] = mask_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data is held until the next read replaces it
  always @(posedge clk_in) begin
    if (srst_in) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_commit) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // byte writes are not offered; every access is a whole word
  always @(posedge clk_in) begin
    if (srst_in) begin
      select_ff    <= `RST_SELECT;
      dir_low_ff   <= `RST_DIR_LOW;
      dir_high_ff  <= `RST_DIR_HIGH;
      data_low_ff  <= `RST_DATA_LOW;
      data_high_ff <= `RST_DATA_HIGH;
      en_low_ff    <= `RST_EN_LOW;
      en_high_ff   <= `RST_EN_HIGH;
      mask_ff      <= `RST_MASK;
    end else if (wr_commit) begin
      case (addr_ff)
        `OFS_SELECT: begin
          select_ff <= hwdata_in[LOW_LINES-1:0];
        end
        `OFS_DIR_LOW: begin
          dir_low_ff <= hwdata_in[LOW_LINES-1:0];
        end
        `OFS_DIR_HIGH: begin
          dir_high_ff <= hwdata_in[`LONE_BIT];
        end
        `OFS_DATA_LOW: begin
          // latch always loads; it reaches the pad only as an output
          data_low_ff <= hwdata_in[LOW_LINES-1:0];
        end
        `OFS_DATA_HIGH: begin
          data_high_ff <= hwdata_in[`HI_SELECT_BIT:`HI_DATA_BIT];
        end
        `OFS_EN_LOW: begin
          en_low_ff <= hwdata_in[LOW_LINES-1:0];
        end
        `OFS_EN_HIGH: begin
          en_high_ff <= hwdata_in[`LONE_BIT];
        end
        `OFS_IRQ_MASK: begin
          mask_ff <= hwdata_in[`STAT_CHANGE_BIT];
        end
        default: begin
          // flags, status and unmapped offsets ignore plain writes
        end
      endcase
    end
  end

  // ----------------------------------------
  // change flags
  // ----------------------------------------
  // a read of either flag register clears all nine flags; an edge in the same cycle survives
  always @(posedge clk_in) begin
    if (srst_in) begin
      flag_ff <= `RST_FLAGS;
    end else if (flag_read) begin
      flag_ff <= hit;
    end else begin
      flag_ff <= flag_ff | hit;
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  wire stat_clear;  // write of one to the status bit
  assign stat_clear = wr_commit & (addr_ff == `OFS_IRQ_STATUS) &
                      hwdata_in[`STAT_CHANGE_BIT];

  // set wins over a clear arriving in the same cycle
  always @(posedge clk_in) begin
    if (srst_in) begin
      stat_ff <= `RST_STAT;
    end else if (|hit) begin
      stat_ff <= 1'b1;
    end else if (stat_clear) begin
      stat_ff <= 1'b0;
    end
  end

  assign irq_out = stat_ff & mask_ff;

  // shared line stays low while any flag waits for its read
  assign peripheral_irq_line_n_out = ~(|flag_ff);

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  // registered so the pads never glitch on a mux change
  always @(posedge clk_in) begin
    if (srst_in) begin
      pad_out_ff <= {LINES{1'b0}};
      pad_oe_ff  <= {LINES{1'b0}};
      pull_ff    <= {LINES{1'b1}};
    end else begin
      // general-purpose lines use the latch, others the shared function
      pad_out_ff <= (gp_mode & dout_all) | (~gp_mode & alt_drive_in);
      pad_oe_ff  <= (gp_mode & dir_all) | (~gp_mode & alt_oe_in);
      // pull-downs stay on; a driver simply overpowers them
      pull_ff    <= {LINES{1'b1}};
    end
  end

  assign pad_out          = pad_out_ff;
  assign pad_oe_out       = pad_oe_ff;
  assign pull_down_en_out = pull_ff;

endmodule

//--- gpio_port_assertions.sv
`timescale 1ns/1ps
`include "gpio_port_consts.vh"

// ------------------------------
// port-level timing checks
// ------------------------------
module gpio_port_assertions #(
  parameter LOW_LINES = 8
) (
  // clock and reset
  input wire                 clk_in,
  input wire                 srst_in,
  // bus
  input wire                 hsel_in,
  input wire [31:0]          haddr_in,
  input wire [1:0]           htrans_in,
  input wire                 hwrite_in,
  input wire                 hready_in,
  input wire                 hreadyout_out,
  input wire                 hresp_out,
  // pads and interrupts
  input wire [LOW_LINES:0]   pad_in,
  input wire [LOW_LINES:0]   pad_oe_out,
  input wire [LOW_LINES:0]   pull_down_en_out,
  input wire [LOW_LINES:0]   alt_level_out,
  input wire                 peripheral_irq_line_n_out,
  input wire                 irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // transfers accepted at this edge
  wire take    = hsel_in & htrans_in[1] & hready_in;
  wire rd_take = take & ~hwrite_in;
  wire wr_take = take & hwrite_in;

  property p_read_wait; rd_take |=> !hreadyout_out ##1 hreadyout_out; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_zero; wr_take |=> hreadyout_out; endproperty
  a_write_zero: assert property (p_write_zero) else $error("write stalled");
  property p_okay; hresp_out == `HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  // quiet outputs in the first cycle after release
  property p_reset_quiet;
    $fell(srst_in) |-> pad_oe_out == 0 && peripheral_irq_line_n_out && !irq_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs wrong");
  property p_pull_down; &pull_down_en_out; endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down off");
  // two flops between pad and level; skip cycles still fed by reset
  property p_level_sync;
    !$past(srst_in) && !$past(srst_in, 2) |-> alt_level_out == $past(pad_in, 2);
  endproperty
  a_level_sync: assert property (p_level_sync) else $error("pad level latency wrong");
  // a first flag needs a pad change three edges back
  property p_flag_delay;
    $fell(peripheral_irq_line_n_out) |-> $past(pad_in, 3) != $past(pad_in, 4);
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag without pad change");
  // with no hit racing the clear, the line is released after a flag read;
  // a hit in the wait cycle needs a pad change three edges before the check
  property p_flag_clear;
    (rd_take && haddr_in[7:0] == `OFS_FLAG_LOW) ##2 ($past(pad_in, 3) == $past(pad_in, 4))
      |-> peripheral_irq_line_n_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("irq held after read");
endmodule

bind gpio_port gpio_port_assertions #(.LOW_LINES(LOW_LINES)) i_chk (
  .clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .pad_in(pad_in),
  .pad_oe_out(pad_oe_out), .pull_down_en_out(pull_down_en_out),
  .alt_level_out(alt_level_out), .peripheral_irq_line_n_out(peripheral_irq_line_n_out),
  .irq_out(irq_out)
);

//--- board_model.sv
`timescale 1ns/1ps

// ------------------------------
// board side of the nine pads
// ------------------------------
module board_model (
  // device drive
  input wire [8:0]  dev_drive_in,
  input wire [8:0]  dev_oe_in,
  // board drive
  input wire [8:0]  board_drive_in,
  input wire [8:0]  board_oe_in,
  // resolved pad level
  output wire [8:0] pad_out
);
  // the device wins while enabled; a line nobody drives falls to the pull-down
  assign pad_out = (dev_oe_in & dev_drive_in) |
                   (~dev_oe_in & board_oe_in & board_drive_in);
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "gpio_port_consts.vh"

// ------------------------------
// self-checking bench
// ------------------------------
module tb_top;
  logic        clk_in = 0, srst_in = 1, hsel_in = 0, hwrite_in = 0;
  logic [1:0]  htrans_in = 0;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, q;
  logic        hreadyout_out, hresp_out, irq_n, irq_out;
  logic [8:0]  pad, pad_out, pad_oe_out, alt_drive_in = 0, alt_oe_in = 0;
  logic [8:0]  board_drive = 0, board_oe = 0, chg, exp;
  logic [7:0]  sel, dir, en;
  int          fails = 0, total_checks = 0, seed = 76257;

  always #10 clk_in = ~clk_in;

  gpio_port #(.LOW_LINES(8)) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .pad_in(pad), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pull_down_en_out(), .alt_drive_in(alt_drive_in), .alt_oe_in(alt_oe_in),
    .alt_level_out(), .peripheral_irq_line_n_out(irq_n), .irq_out(irq_out)
  );

  board_model i_board (.dev_drive_in(pad_out), .dev_oe_in(pad_oe_out),
    .board_drive_in(board_drive), .board_oe_in(board_oe), .pad_out(pad));

  // one single transfer; hready and read data are taken at rising edges
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // lines that may flag: enabled, general purpose, input; line 8 is set up that way
  function automatic logic [8:0] hits(input logic [8:0] c, input logic [7:0] s, d, e);
    return c & {1'b1, s & ~d & e};
  endfunction

  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the expected run of about 450 cycles
  initial begin
    #400000;
    fails++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    // reset values, last word unmapped; open pads read low
    for (int k = 0; k < 12; k++) begin
      bus(0, 8'(k * 4), 0);
      check("reset_reg", q, k == 0 ? 32'hFF : k == 4 ? 32'h2 : 32'h0);
    end
    // change flags ignore plain writes
    bus(1, `OFS_FLAG_LOW, 32'hFF);
    bus(0, `OFS_FLAG_LOW, 0);
    check("flag_ro", q, 0);
    // mixed directions: outputs read the latch, inputs the pad
    dir = 8'($random(seed));
    en = 8'($random(seed));
    board_oe <= 9'h1FF;
    board_drive <= 9'($random(seed));
    bus(1, `OFS_DIR_LOW, {24'h0, dir});
    bus(1, `OFS_DATA_LOW, {24'h0, en});
    bus(1, `OFS_DIR_HIGH, 1);
    bus(1, `OFS_DATA_HIGH, 3);
    bus(0, `OFS_DATA_LOW, 0);
    check("data_low", q, {24'h0, (dir & en) | (~dir & board_drive[7:0])});
    check("pad_oe", 32'(pad_oe_out), {23'h0, 1'b1, dir});
    check("pad_drive", 32'(pad_oe_out & pad_out), {23'h0, 1'b1, dir & en});
    // hand every pad to its alternate function
    alt_drive_in <= 9'($random(seed));
    alt_oe_in <= 9'($random(seed));
    bus(1, `OFS_SELECT, 0);
    bus(1, `OFS_DATA_HIGH, 0);
    repeat (2) @(negedge clk_in);
    check("alt_oe", 32'(pad_oe_out), 32'(alt_oe_in));
    check("alt_drive", 32'(pad_oe_out & pad_out), 32'(alt_drive_in & alt_oe_in));
    // change detection under random select, direction and enable
    for (int i = 0; i < 6; i++) begin
      sel = 8'($random(seed));
      dir = 8'($random(seed));
      en = 8'($random(seed));
      bus(1, `OFS_SELECT, {24'h0, sel});
      bus(1, `OFS_DIR_LOW, {24'h0, dir});
      bus(1, `OFS_DIR_HIGH, 0);
      bus(1, `OFS_DATA_HIGH, 2);
      bus(1, `OFS_EN_LOW, {24'h0, en});
      bus(1, `OFS_EN_HIGH, 1);
      bus(1, `OFS_IRQ_MASK, i % 2);
      // flush flags raised by reconfiguring the pads
      repeat (6) @(posedge clk_in);
      bus(0, `OFS_FLAG_LOW, 0);
      bus(1, `OFS_IRQ_STATUS, 1);
      chg = (i == 0) ? 9'h100 : 9'($random(seed));
      board_drive <= board_drive ^ chg;
      repeat (6) @(negedge clk_in);
      exp = hits(chg, sel, dir, en);
      check("irq_n", 32'(irq_n), 32'(exp == 0));
      check("irq", 32'(irq_out), 32'(exp != 0 && i % 2 == 1));
      // first read returns its half, second finds everything cleared
      bus(0, i[1] ? `OFS_FLAG_LOW : `OFS_FLAG_HIGH, 0);
      check("flag_first", q, i[1] ? {24'h0, exp[7:0]} : {31'h0, exp[8]});
      bus(0, i[1] ? `OFS_FLAG_HIGH : `OFS_FLAG_LOW, 0);
      check("flag_second", q, 0);
      check("irq_n_clr", 32'(irq_n), 1);
      bus(0, `OFS_IRQ_STATUS, 0);
      check("status", q, 32'(exp != 0));
      bus(1, `OFS_IRQ_STATUS, 1);
      bus(0, `OFS_IRQ_STATUS, 0);
      check("status_clr", q, 0);
    end
    print_verdict;
  end
endmodule
